// ===== include/rt_dma_pkg.sv
// Shared constants, states and carriers of the terminal subsystem transfer block
package rt_dma_pkg;
    localparam int CLK_MHZ          = 100;
    localparam int GRANT_TIMEOUT_US = 10;
    localparam int GRANT_TIMEOUT_CYC = GRANT_TIMEOUT_US * CLK_MHZ;
    localparam int RD_STROBE_CYC    = 3;
    localparam int WORD_CYC         = 3;
    localparam logic [1:0] CAPTURE_PHASE = 2'h1;
    localparam logic [1:0] WSTROBE_PHASE = 2'h1;
    localparam logic [1:0] LAST_PHASE    = 2'h2;
    localparam logic [4:0] SA_MODE_LO    = 5'h00;
    localparam logic [4:0] SA_MODE_HI    = 5'h1F;
    localparam logic [4:0] SA_WRAP       = 5'h1E;
    localparam logic [5:0] CFG_RESET     = 6'h3F;
    localparam logic [5:0] WORDS_ZERO_WC = 6'h20;
    localparam logic [2:0] STARTUP_CYC   = 3'h5;
    localparam int FIFO_DEPTH = 8;
    localparam int DATA_W     = 16;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_REQ   = 3'h1,
        ST_RD    = 3'h3,
        ST_WR    = 3'h2,
        ST_BURST = 3'h6,
        ST_CFG   = 3'h7,
        ST_REL   = 3'h5
    } dma_state_e;

    typedef struct packed {
        logic       broadcast;
        logic       transmit;
        logic [4:0] subaddress;
        logic [4:0] word_count;
    } cmd_s;
endpackage : rt_dma_pkg

// ===== rtl/word_fifo.sv
// Parameterised valid/ready word FIFO used in the receive data path
`timescale 1ns/1ns
module word_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)
(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      level_r;
    logic             push;
    logic             pop;

    // Honest full and empty from the fill level
    assign in_ready  = (level_r != (AW+1)'(DEPTH));
    assign out_valid = (level_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_r];

    // Storage has no reset; only pointers and level carry state
    always_ff @(posedge clock)
    begin
        if (push)
            mem[wr_ptr_r] <= in_data;
    end

    // Pointer and level bookkeeping
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            level_r  <= '0;
        end
        else if (flush)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            level_r  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            level_r <= level_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : word_fifo

// ===== rtl/rt_subsystem_dma.sv
// Subsystem-side command latch and DMA handshake logic of a simple remote terminal
`timescale 1ns/1ns
// Operation
// - Latch broadcast flag per new command
// - Latch transmit/receive direction per command
// - Latch five-bit subaddress per command
// - Count outputs first show word count field
// - Receive count steps per word moved
// - Burst drain restarts count, three cycles/word
// - Transmit count steps per word read
// - Mode code held until next command
// - Request low asks for data bus
// - Acknowledge low frames every data transfer
// - Strapped auto-config handshake after reset
// - Per-word acknowledge pulses in listed cases
// - Burst acknowledge held, three cycles/word
// - Timeout flag low on missing grant
// - Read strobe low exactly three cycles
// - Capture read data before strobe rises
// - Write strobe low one cycle
// - Six config bits from low data bits
module rt_subsystem_dma
    import rt_dma_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             cmd_valid,
    input  wire cmd_s             cmd_in,
    input  wire logic             burst_mode,
    input  wire logic             sa30_autowrap,
    input  wire logic             rx_valid,
    output logic                  rx_ready,
    input  wire logic [WIDTH-1:0] rx_data,
    input  wire logic             rx_msg_done,
    input  wire logic             rx_msg_ok,
    input  wire logic             tx_fetch,
    output logic                  tx_word_valid,
    output logic      [WIDTH-1:0] tx_word,
    input  wire logic             auto_config_n,
    output logic      [5:0]       config_out,
    output logic                  terminal_active_n,
    output logic                  latched_broadcast_flag,
    output logic                  transmit_flag,
    output logic      [4:0]       subaddress,
    output logic      [4:0]       word_count_out,
    output logic                  xfer_request_n,
    input  wire logic             xfer_grant_n,
    output logic                  xfer_acknowledge_n,
    output logic                  handshake_timeout_n,
    output logic                  read_strobe_n,
    output logic                  write_strobe_n,
    input  wire logic [WIDTH-1:0] data_in,
    output logic      [WIDTH-1:0] data_out,
    output logic                  data_oe_n
);
    dma_state_e  state_r;
    cmd_s        cmd_r;
    logic [1:0]  sync1_r, sync2_r, sync3_r, pins_r;
    logic        grant_low;
    logic [1:0]  phase_r;
    logic [9:0]  wait_cnt_r;
    logic        timeout;
    logic [2:0]  startup_r;
    logic        cfg_pending_r, fetch_pending_r, burst_pending_r;
    logic [4:0]  cur_cnt_r;
    logic [5:0]  drained_r;
    logic        mode_cmd, per_word, word_end;
    logic        fifo_valid, fifo_pop, fifo_flush, step, restart;
    logic [WIDTH-1:0] fifo_data;
    dma_state_e  job_nxt;

    // Mode commands use subaddress 0 or 31
    function automatic logic is_mode(input logic [4:0] sa);
        is_mode = (sa == SA_MODE_LO) || (sa == SA_MODE_HI);
    endfunction : is_mode

    assign mode_cmd = is_mode(cmd_r.subaddress);
    // Wrap subaddress without autowrap always moves word by word
    assign per_word = !burst_mode || (cmd_r.subaddress == SA_WRAP && !sa30_autowrap);
    assign word_end = (phase_r == LAST_PHASE);
    assign timeout  = (wait_cnt_r == 10'(GRANT_TIMEOUT_CYC - 1));

    // Three-stage synchroniser; a change counts once stages two and three agree
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_r <= 2'h3;
            sync2_r <= 2'h3;
            sync3_r <= 2'h3;
            pins_r  <= 2'h3;
        end
        else
        begin
            sync1_r <= {auto_config_n, xfer_grant_n};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            for (int i = 0; i < 2; i++)
                if (sync2_r[i] == sync3_r[i])
                    pins_r[i] <= sync3_r[i];
        end
    end
    assign grant_low = !pins_r[0];

    // Command latch: all fields replaced by each new command word
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            cmd_r <= '0;
        else if (cmd_valid)
            cmd_r <= cmd_in;
    end
    assign latched_broadcast_flag = cmd_r.broadcast;
    assign transmit_flag          = cmd_r.transmit;
    assign subaddress             = cmd_r.subaddress;

    // Startup: strap is judged only after the synchroniser has settled
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            startup_r         <= '0;
            cfg_pending_r     <= 1'b0;
            terminal_active_n <= 1'b0;
            config_out        <= CFG_RESET;
        end
        else
        begin
            if (startup_r != STARTUP_CYC)
            begin
                startup_r <= startup_r + 1'b1;
                // Three flops plus agreement: the strap is first trustworthy here
                if (startup_r == STARTUP_CYC - 3'h1)
                begin
                    cfg_pending_r     <= !pins_r[1];
                    terminal_active_n <= pins_r[1];
                end
            end
            if (state_r == ST_CFG && phase_r == CAPTURE_PHASE)
                config_out <= data_in[5:0];
            if (state_r == ST_CFG && word_end)
            begin
                cfg_pending_r     <= 1'b0;
                terminal_active_n <= 1'b1;
            end
        end
    end

    // Work pending; a new request wins over the clear in the same cycle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fetch_pending_r <= 1'b0;
            burst_pending_r <= 1'b0;
        end
        else
        begin
            if (tx_fetch && !mode_cmd)
                fetch_pending_r <= 1'b1;
            else if ((state_r == ST_RD && word_end) || (state_r == ST_REQ && timeout))
                fetch_pending_r <= 1'b0;
            if (rx_msg_done && rx_msg_ok && !per_word && !mode_cmd)
                burst_pending_r <= 1'b1;
            else if (cmd_valid || (state_r == ST_BURST && word_end && fifo_pop
                     && drained_r + 6'h1 == (cmd_r.word_count == '0 ? WORDS_ZERO_WC
                     : {1'b0, cmd_r.word_count})) || (state_r == ST_REQ && timeout))
                burst_pending_r <= 1'b0;
        end
    end

    // Next job: configuration, then transmit fetch, then receive delivery
    always_comb
    begin
        job_nxt = ST_IDLE;
        if (cfg_pending_r && startup_r == STARTUP_CYC)
            job_nxt = ST_CFG;
        else if (cfg_pending_r || startup_r != STARTUP_CYC)
            job_nxt = ST_IDLE;
        else if (fetch_pending_r)
            job_nxt = ST_RD;
        else if (fifo_valid && per_word)
            job_nxt = ST_WR;
        else if (fifo_valid && burst_pending_r)
            job_nxt = ST_BURST;
    end

    // Handshake sequencer
    dma_state_e job_r;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ST_IDLE;
            job_r   <= ST_IDLE;
            phase_r <= '0;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                    if (job_nxt != ST_IDLE)
                    begin
                        job_r   <= job_nxt;
                        state_r <= ST_REQ;
                    end
                ST_REQ:
                    if (grant_low)
                    begin
                        state_r <= job_r;
                        phase_r <= '0;
                    end
                    else if (timeout)
                        state_r <= ST_IDLE;
                ST_RD, ST_CFG, ST_WR:
                    begin
                        phase_r <= word_end ? 2'h0 : phase_r + 2'h1;
                        if (word_end)
                            state_r <= ST_REL;
                    end
                ST_BURST:
                    begin
                        phase_r <= word_end ? 2'h0 : phase_r + 2'h1;
                        if (word_end && !burst_pending_r)
                            state_r <= ST_REL;
                        else if (word_end && fifo_pop && drained_r + 6'h1 ==
                                 (cmd_r.word_count == '0 ? WORDS_ZERO_WC
                                 : {1'b0, cmd_r.word_count}))
                            state_r <= ST_REL;
                    end
                ST_REL:
                    state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Grant wait counter; sized for ten microseconds at the system clock
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            wait_cnt_r <= '0;
        else if (state_r == ST_REQ && !timeout)
            wait_cnt_r <= wait_cnt_r + 10'h1;
        else
            wait_cnt_r <= '0;
    end

    // Timeout flag holds until the next command word
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            handshake_timeout_n <= 1'b1;
        else if (state_r == ST_REQ && timeout && !grant_low)
            handshake_timeout_n <= 1'b0;
        else if (cmd_valid)
            handshake_timeout_n <= 1'b1;
    end

    // Handshake and strobe pins follow the state directly
    assign xfer_request_n     = (state_r != ST_REQ);
    assign xfer_acknowledge_n = !(state_r == ST_RD || state_r == ST_CFG
                                  || state_r == ST_WR || state_r == ST_BURST);
    assign read_strobe_n      = !(state_r == ST_RD || state_r == ST_CFG);
    assign write_strobe_n     = !((state_r == ST_WR || state_r == ST_BURST)
                                  && phase_r == WSTROBE_PHASE);
    assign data_oe_n          = !(state_r == ST_WR || state_r == ST_BURST);
    assign data_out           = fifo_data;
    // Words leave the FIFO at the end of their three-cycle slot
    assign fifo_pop   = (state_r == ST_WR || state_r == ST_BURST) && word_end;
    assign fifo_flush = cmd_valid && !cmd_in.transmit;

    // Transmit word capture one cycle before the strobe rises
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_word       <= '0;
            tx_word_valid <= 1'b0;
        end
        else
        begin
            tx_word_valid <= (state_r == ST_RD && phase_r == CAPTURE_PHASE);
            if (state_r == ST_RD && phase_r == CAPTURE_PHASE)
                tx_word <= data_in;
        end
    end

    // Count steps: per word read, per word into the FIFO, per word delivered
    assign restart = state_r == ST_BURST && phase_r == '0 && drained_r == '0;
    assign step    = !mode_cmd && ((state_r == ST_REQ && grant_low
                     && (job_r == ST_RD || job_r == ST_WR))
                     || (rx_valid && rx_ready && !per_word && !burst_pending_r)
                     || (state_r == ST_BURST && phase_r == '0));
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            word_count_out <= '0;
            cur_cnt_r      <= '0;
            drained_r      <= '0;
        end
        else if (cmd_valid)
        begin
            word_count_out <= cmd_in.word_count;
            cur_cnt_r      <= '0;
            drained_r      <= '0;
        end
        else
        begin
            if (restart)
            begin
                word_count_out <= '0;
                cur_cnt_r      <= 5'h1;
            end
            else if (step)
            begin
                word_count_out <= cur_cnt_r;
                cur_cnt_r      <= cur_cnt_r + 5'h1;
            end
            if (state_r == ST_BURST && fifo_pop)
                drained_r <= drained_r + 6'h1;
        end
    end

    // Receive buffer; a full FIFO stalls the decoder through rx_ready
    word_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .flush     (fifo_flush),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   (rx_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // Checks kept beside the logic they watch
    sequence rd_low3;
        !read_strobe_n [*3] ##1 read_strobe_n;
    endsequence
    a_read_three: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(read_strobe_n) |-> rd_low3) else $error("read strobe width wrong");
    a_write_one: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(write_strobe_n) |=> write_strobe_n) else $error("write strobe not one cycle");
    a_capture_time: assert property (@(posedge clock) disable iff (!rst_n)
        tx_word_valid |-> !read_strobe_n ##1 read_strobe_n) else $error("capture misplaced");
    a_ack_frames: assert property (@(posedge clock) disable iff (!rst_n)
        (!read_strobe_n || !write_strobe_n) |-> !xfer_acknowledge_n)
        else $error("strobe outside acknowledge");
    a_req_release: assert property (@(posedge clock) disable iff (!rst_n)
        !xfer_acknowledge_n |-> xfer_request_n) else $error("request with acknowledge");
    // Run length of a low request; a counter avoids a very long delay range
    logic [10:0] req_low_run_r;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            req_low_run_r <= '0;
        else if (!xfer_request_n)
            req_low_run_r <= req_low_run_r + 11'h1;
        else
            req_low_run_r <= '0;
    end
    a_timeout_bound: assert property (@(posedge clock) disable iff (!rst_n)
        !xfer_request_n |-> req_low_run_r < 11'(GRANT_TIMEOUT_CYC)) else $error("request stuck");
    a_timeout_flag: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(handshake_timeout_n) |-> $past(!xfer_request_n)) else $error("flag without request");
    a_cmd_latch: assert property (@(posedge clock) disable iff (!rst_n)
        cmd_valid |=> word_count_out == $past(cmd_in.word_count)
        && subaddress == $past(cmd_in.subaddress)) else $error("command not latched");
    a_mode_hold: assert property (@(posedge clock) disable iff (!rst_n)
        mode_cmd && !cmd_valid |=> $stable(word_count_out)) else $error("mode code moved");
    a_burst_slot: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == ST_BURST && phase_r == '0) |-> ##1 !write_strobe_n ##1 write_strobe_n
        && !xfer_acknowledge_n) else $error("burst slot not three cycles");
endmodule : rt_subsystem_dma

// ===== test/subsys_model.sv
// Behavioural external subsystem: grants the bus, serves reads, takes writes
`timescale 1ns/1ns
module subsys_model
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        no_grant,
    input  wire logic [15:0] rd_word,
    input  wire logic        xfer_request_n,
    input  wire logic        xfer_acknowledge_n,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic [15:0] data_out,
    input  wire logic        data_oe_n,
    output logic             xfer_grant_n,
    output logic      [15:0] data_in,
    output logic      [15:0] wr_word,
    output logic      [7:0]  wr_count,
    output logic      [7:0]  ack_falls,
    output logic      [7:0]  ack_len,
    output logic      [7:0]  strobe_len
);
    logic [1:0] req_dly_r;
    logic [7:0] rd_low_r;
    logic [7:0] ack_low_r;

    // Grant trails the request by two cycles; no_grant models a hung subsystem
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n)
            req_dly_r <= 2'h3;
        else
            req_dly_r <= {req_dly_r[0], xfer_request_n};
    assign xfer_grant_n = no_grant | req_dly_r[1];

    // Buffer is enabled only by the read strobe; otherwise the bus shows junk
    assign data_in = read_strobe_n ? ~rd_word : rd_word;

    // Write data taken while the strobe is low, which both strobe edges bracket
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_word   <= 16'h0000;
            wr_count  <= 8'h00;
            ack_falls <= 8'h00;
            ack_len   <= 8'h00;
            ack_low_r <= 8'h00;
            rd_low_r  <= 8'h00;
            strobe_len <= 8'h00;
        end
        else
        begin
            if (!write_strobe_n)
            begin
                wr_word  <= data_oe_n ? ~data_out : data_out;
                wr_count <= wr_count + 8'h01;
            end
            ack_low_r <= xfer_acknowledge_n ? 8'h00 : ack_low_r + 8'h01;
            if (!xfer_acknowledge_n && ack_low_r == 8'h00)
                ack_falls <= ack_falls + 8'h01;
            if (xfer_acknowledge_n && ack_low_r != 8'h00)
                ack_len <= ack_low_r;
            rd_low_r <= read_strobe_n ? 8'h00 : rd_low_r + 8'h01;
            if (read_strobe_n && rd_low_r != 8'h00)
                strobe_len <= rd_low_r;
        end
    end
endmodule : subsys_model

// ===== test/rt_subsystem_dma_tb.sv
// Self-checking bench of the terminal subsystem transfer block
`timescale 1ns/1ns
module rt_subsystem_dma_tb
    import rt_dma_pkg::*;
;
    logic        clock = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, burst_mode = 1'b0;
    logic        sa30_autowrap = 1'b0, rx_valid = 1'b0, rx_msg_done = 1'b0;
    logic        rx_msg_ok = 1'b0, tx_fetch = 1'b0, auto_config_n = 1'b0, no_grant = 1'b0;
    cmd_s        cmd_in = '0;
    logic [15:0] rx_data = 16'h0000, rd_word = 16'h0015;
    logic        rx_ready, tx_word_valid, terminal_active_n, latched_broadcast_flag;
    logic        transmit_flag, xfer_request_n, xfer_grant_n, xfer_acknowledge_n;
    logic        handshake_timeout_n, read_strobe_n, write_strobe_n, data_oe_n;
    logic [15:0] tx_word, data_in, data_out, wr_word;
    logic [5:0]  config_out;
    logic [4:0]  subaddress, word_count_out;
    logic [7:0]  wr_count, ack_falls, ack_len, strobe_len, tgt;
    int          fail_count = 0, num_checks = 0;

    rt_subsystem_dma rt_subsystem_dma_inst (.clock, .rst_n, .cmd_valid, .cmd_in, .burst_mode,
        .sa30_autowrap, .rx_valid, .rx_ready, .rx_data, .rx_msg_done, .rx_msg_ok, .tx_fetch,
        .tx_word_valid, .tx_word, .auto_config_n, .config_out, .terminal_active_n,
        .latched_broadcast_flag, .transmit_flag, .subaddress, .word_count_out, .xfer_request_n,
        .xfer_grant_n, .xfer_acknowledge_n, .handshake_timeout_n, .read_strobe_n,
        .write_strobe_n, .data_in, .data_out, .data_oe_n);
    subsys_model subsys_model_inst (.clock, .rst_n, .no_grant, .rd_word, .xfer_request_n,
        .xfer_acknowledge_n, .read_strobe_n, .write_strobe_n, .data_out, .data_oe_n,
        .xfer_grant_n, .data_in, .wr_word, .wr_count, .ack_falls, .ack_len, .strobe_len);

    // 100 MHz clock
    always #5 clock = ~clock;

    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task wrap_up();
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    function automatic bit cond(input int sel);
        case (sel)
            0:       return tx_word_valid === 1'b1;
            1:       return terminal_active_n === 1'b1;
            2:       return wr_count === tgt;
            default: return handshake_timeout_n === 1'b0;
        endcase
    endfunction : cond

    // Bounded wait; running out counts a mismatch and ends the run
    task await(input int sel, input int lim);
        int n;
        n = 0;
        while (!cond(sel) && n < lim)
        begin
            @(negedge clock);
            n++;
        end
        if (!cond(sel))
        begin
            fail_count++;
            $display("Error at %0t: wait %0d ran out", $time, sel);
            wrap_up();
        end
    endtask : await

    task send_cmd(input cmd_s c);
        cmd_in = c;
        cmd_valid = 1'b1;
        @(negedge clock);
        cmd_valid = 1'b0;
        @(negedge clock);
        check(16'(latched_broadcast_flag), 16'(c.broadcast));
        check(16'(transmit_flag), 16'(c.transmit));
        check(16'(subaddress), 16'(c.subaddress));
        check(16'(word_count_out), 16'(c.word_count));
    endtask : send_cmd

    task config_read();
        check(16'(terminal_active_n), 16'h0000);
        await(1, 300);
        check(16'(config_out), 16'h0015);
        check(16'(ack_falls), 16'h0001);
        $display("config_read done");
    endtask : config_read

    task fetch(input logic [15:0] w, input logic [4:0] cnt);
        rd_word = w;
        tx_fetch = 1'b1;
        @(negedge clock);
        tx_fetch = 1'b0;
        await(0, 60);
        check(tx_word, w);
        repeat (3) @(negedge clock);
        check(16'(strobe_len), 16'h0003);
        check(16'(ack_len), 16'h0003);
        check(16'(word_count_out), 16'(cnt));
    endtask : fetch

    task tx_test();
        send_cmd('{1'b0, 1'b1, 5'h03, 5'h02});
        fetch(16'h1234, 5'h00);
        fetch(16'hBEEF, 5'h01);
        $display("tx_test done");
    endtask : tx_test

    task mode_test();
        send_cmd('{1'b1, 1'b0, 5'h1F, 5'h09});
        repeat (20) @(negedge clock);
        check(16'(word_count_out), 16'h0009);
        $display("mode_test done");
    endtask : mode_test

    // Receive message; per-word acknowledge unless burst delivery applies
    task rx_msg(input logic bm, input logic [4:0] sa, input logic [4:0] wc);
        logic [7:0] a0;
        logic       per;
        per = !bm || (sa == 5'h1E && !sa30_autowrap);
        burst_mode = bm;
        send_cmd('{1'b0, 1'b0, sa, wc});
        check(16'(rx_ready), 16'h0001);
        a0 = ack_falls;
        tgt = wr_count + 8'(wc);
        rx_valid = 1'b1;
        for (int i = 0; i < wc; i++)
        begin
            rx_data = 16'hA500 + 16'(i);
            @(negedge clock);
        end
        rx_valid = 1'b0;
        rx_msg_done = 1'b1;
        rx_msg_ok = 1'b1;
        @(negedge clock);
        rx_msg_done = 1'b0;
        rx_msg_ok = 1'b0;
        await(2, 500);
        repeat (4) @(negedge clock);
        check(16'(wr_count), 16'(tgt));
        check(wr_word, 16'hA4FF + 16'(wc));
        check(16'(ack_falls - a0), per ? 16'(wc) : 16'h0001);
        check(16'(ack_len), per ? 16'h0003 : 16'h0003 * 16'(wc));
        check(16'(word_count_out), 16'(wc) - 16'h0001);
        $display("rx_msg done");
    endtask : rx_msg

    task grant_timeout();
        no_grant = 1'b1;
        send_cmd('{1'b0, 1'b1, 5'h04, 5'h01});
        tx_fetch = 1'b1;
        @(negedge clock);
        tx_fetch = 1'b0;
        @(negedge clock);
        check(16'(xfer_request_n), 16'h0000);
        repeat (990) @(negedge clock);
        check(16'(handshake_timeout_n), 16'h0001);
        await(3, 40);
        check(16'(xfer_request_n), 16'h0001);
        check(16'(xfer_acknowledge_n), 16'h0001);
        no_grant = 1'b0;
        $display("grant_timeout done");
    endtask : grant_timeout

    // Main sequence
    initial
    begin
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        config_read();
        tx_test();
        mode_test();
        rx_msg(1'b0, 5'h02, 5'h02);
        rx_msg(1'b1, 5'h02, 5'h03);
        rx_msg(1'b1, 5'h1E, 5'h02);
        sa30_autowrap = 1'b1;
        rx_msg(1'b1, 5'h1E, 5'h02);
        grant_timeout();
        wrap_up();
    end
endmodule : rt_subsystem_dma_tb
